// >>> pkg/i2c_target_pkg.sv
// Constants, types and helpers shared by the two-wire target interface
package i2c_target_pkg;

    // ==========================================================
    // Addressing and byte framing
    localparam logic [6:0] TARGET_ADDR = 7'h5c;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [7:0] INDEX_STEP = 8'h01;

    // ==========================================================
    // Timing: time-out in ms at the system clock rate
    localparam int CLK_FREQ_KHZ = 125000;
    localparam int TOUT_SHORT_MS = 32;
    localparam int TOUT_LONG_MS = 64;
    localparam int TOUT_SHORT_CYCLES = TOUT_SHORT_MS * CLK_FREQ_KHZ;
    localparam int TOUT_LONG_CYCLES = TOUT_LONG_MS * CLK_FREQ_KHZ;
    localparam int TOUT_WIDTH = 24;

    // ==========================================================
    // Timing: spike suppression on the link sampling clock
    localparam int SPIKE_NS = 20;
    localparam int LINK_PERIOD_NS = 12;
    localparam int SPIKE_SAMPLES = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS + 1;

    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        LINK_IDLE = 4'b0000,
        LINK_ADDR = 4'b0001,
        LINK_ADDR_ACK = 4'b0010,
        LINK_INDEX = 4'b0011,
        LINK_INDEX_ACK = 4'b0100,
        LINK_WDATA = 4'b0101,
        LINK_WDATA_ACK = 4'b0110,
        LINK_RDATA = 4'b0111,
        LINK_RDATA_ACK = 4'b1000,
        LINK_IGNORE = 4'b1001
    } link_state_t;

    typedef struct packed {
        logic [7:0] index;
        logic [7:0] data;
    } reg_write_t;

    // Bundle of events sent from the link domain as toggles
    typedef struct packed {
        logic start;
        logic sclFall;
        logic stop;
        logic write;
        logic read;
    } link_events_t;

    // Edge of a synchronised toggle
    function automatic logic toggled(input logic newer, input logic older);
        return newer ^ older;
    endfunction

endpackage

// >>> rtl/pin_spike_filter.sv
// Two-flop synchroniser and spike filter for one bus pin
module pin_spike_filter #(
    parameter int SAMPLES = i2c_target_pkg::SPIKE_SAMPLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Pin and filtered level
    input wire logic pinIn,
    output logic level
);

    localparam int CW = $clog2(SAMPLES + 1);
    localparam logic [CW-1:0] LAST = CW'(SAMPLES - 1);

    logic [1:0] sync_reg, sync_next;
    logic [CW-1:0] count_reg, count_next;
    logic level_reg, level_next;

    // ==========================================================
    // Change accepted only after a stable run longer than a spike
    always_comb begin
        sync_next = {sync_reg[0], pinIn};
        count_next = '0;
        level_next = level_reg;
        // [RL16] glitch suppression
        if (sync_reg[1] != level_reg) begin
            if (count_reg == LAST) begin
                level_next = sync_reg[1];
            end else begin
                count_next = count_reg + CW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sync_reg <= 2'h3;
            count_reg <= '0;
            level_reg <= 1'b1;
        end else begin
            sync_reg <= sync_next;
            count_reg <= count_next;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;

endmodule // pin_spike_filter

// >>> rtl/bus_timeout_timer.sv
// Bus time-out counter with selectable period
module bus_timeout_timer #(
    parameter int WIDTH = i2c_target_pkg::TOUT_WIDTH,
    parameter int SHORT_CYCLES = i2c_target_pkg::TOUT_SHORT_CYCLES,
    parameter int LONG_CYCLES = i2c_target_pkg::TOUT_LONG_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic longSel,
    input wire logic restart,
    input wire logic halt,
    // Result
    output logic expired
);

    logic [WIDTH-1:0] count_reg, count_next;
    logic running_reg, running_next;
    logic expired_reg, expired_next;
    logic [WIDTH-1:0] limit;

    assign limit = longSel ? WIDTH'(LONG_CYCLES - 1) : WIDTH'(SHORT_CYCLES - 1);

    // ==========================================================
    // Counter
    always_comb begin
        count_next = count_reg;
        running_next = running_reg;
        expired_next = 1'b0;
        // [RL18] restart and halt
        if (restart) begin
            count_next = '0;
            running_next = 1'b1;
        end else if (halt) begin
            running_next = 1'b0;
        end else if (running_reg) begin
            // [RL17] period select
            if (count_reg == limit) begin
                running_next = 1'b0;
                expired_next = 1'b1;
            end else begin
                count_next = count_reg + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count_reg <= '0;
            running_reg <= 1'b0;
            expired_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            running_reg <= running_next;
            expired_reg <= expired_next;
        end
    end

    assign expired = expired_reg;

endmodule // bus_timeout_timer

// >>> rtl/battery_monitor_i2c_target.sv
// Two-wire serial target with register access port and bus time-out
//
// Overview of operation
// [RL1] Lines are open-drain; the device only pulls low, never drives high.
// [RL2] Both lines high means the bus is idle.
// [RL3] Controller starts a transfer only while the bus is idle.
// [RL4] Data changes only while the clock is low.
// [RL5] Data falling while clock high is a START.
// [RL6] Data rising while clock high is a STOP.
// [RL7] Only the controller makes START and STOP; device never does.
// [RL8] Bus busy from START to STOP; repeated START acts as START.
// [RL9] Bytes are eight bits; any number of bytes per transfer.
// [RL10] Bytes are shifted most significant bit first both ways.
// [RL11] Controller supplies a ninth clock for the acknowledge bit.
// [RL12] Addressed device acknowledges every byte it receives.
// [RL13] Acknowledger holds data low through the ninth clock high phase.
// [RL14] Controller not-acknowledges the last byte it reads.
// [RL15] After that it sends STOP or repeated START.
// [RL16] Glitches up to the spike limit on both inputs are ignored.
// [RL17] Time-out is 32 ms, or 64 ms with the trim setting.
// [RL18] Timer starts at START, restarts on clock falls, STOP halts it.
// [RL19] First byte is seven-bit address plus direction; ack on match.
// [RL20] Register write: address, index byte, data byte, STOP.
// [RL21] Register read: write index, then read address and one byte.
// [RL22] Unmatched address leaves data released until next START or STOP.
// [RL23] After time-out or STOP the engine idles until a fresh START.
module battery_monitor_i2c_target #(
    parameter int TOUT_SHORT_CYCLES = i2c_target_pkg::TOUT_SHORT_CYCLES,
    parameter int TOUT_LONG_CYCLES = i2c_target_pkg::TOUT_LONG_CYCLES,
    parameter int SPIKE_SAMPLES = i2c_target_pkg::SPIKE_SAMPLES
) (
    // System clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link sampling clock
    input wire logic linkClk,
    // Trim strap, caught during reset
    input wire logic trimLong,
    // Serial clock pin
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    // Serial data pin
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Register access side
    output i2c_target_pkg::reg_write_t regWrite,
    output logic regWriteValid,
    output logic [7:0] regReadIndex,
    input wire logic [7:0] regReadData,
    output logic busBusy
);

    // ==========================================================
    // Link domain reset
    logic [1:0] linkRst_reg, linkRst_next;
    logic linkReset;

    assign linkRst_next = {linkRst_reg[0], reset};
    assign linkReset = linkRst_reg[1];

    always_ff @(posedge linkClk) begin
        linkRst_reg <= linkRst_next;
    end

    // ==========================================================
    // Pin conditioning
    logic sclLvl, sdaLvl;

    pin_spike_filter #(.SAMPLES(SPIKE_SAMPLES)) sclFilter (
        .clk(linkClk),
        .reset(linkReset),
        .pinIn(sclIn),
        .level(sclLvl)
    );

    pin_spike_filter #(.SAMPLES(SPIKE_SAMPLES)) sdaFilter (
        .clk(linkClk),
        .reset(linkReset),
        .pinIn(sdaIn),
        .level(sdaLvl)
    );

    // ==========================================================
    // Toggles from system domain into link domain
    logic [1:0] toSync1_reg, toSync2_reg, toSync3_reg;
    logic [1:0] toSync1_next, toSync2_next, toSync3_next;
    logic timeoutTgl_reg, rdAckTgl_reg;
    logic timeoutHit, rdAckHit;

    assign toSync1_next = {timeoutTgl_reg, rdAckTgl_reg};
    assign toSync2_next = toSync1_reg;
    assign toSync3_next = toSync2_reg;
    assign timeoutHit = i2c_target_pkg::toggled(toSync2_reg[1], toSync3_reg[1]);
    assign rdAckHit = i2c_target_pkg::toggled(toSync2_reg[0], toSync3_reg[0]);

    always_ff @(posedge linkClk) begin
        if (linkReset) begin
            toSync1_reg <= 2'h0;
            toSync2_reg <= 2'h0;
            toSync3_reg <= 2'h0;
        end else begin
            toSync1_reg <= toSync1_next;
            toSync2_reg <= toSync2_next;
            toSync3_reg <= toSync3_next;
        end
    end

    // ==========================================================
    // Link engine
    i2c_target_pkg::link_state_t state_reg, state_next;
    i2c_target_pkg::link_events_t evTgl_reg, evTgl_next;
    i2c_target_pkg::reg_write_t wrHold_reg, wrHold_next;
    logic [3:0] bitCnt_reg, bitCnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] index_reg, index_next;
    logic [7:0] rdHold_reg, rdHold_next;
    logic [7:0] rdDataX_reg;
    logic sclPrev_reg, sdaPrev_reg;
    logic drive_reg, drive_next;
    logic dirRead_reg, dirRead_next;
    logic hostAck_reg, hostAck_next;
    logic busy_reg, busy_next;
    logic startEv, stopEv, sclRise, sclFall, byteDone;

    // [RL5] start detect
    assign startEv = sclLvl & sclPrev_reg & sdaPrev_reg & ~sdaLvl;
    // [RL6] stop detect
    assign stopEv = sclLvl & sclPrev_reg & ~sdaPrev_reg & sdaLvl;
    assign sclRise = sclLvl & ~sclPrev_reg;
    assign sclFall = ~sclLvl & sclPrev_reg;
    assign byteDone = sclFall && (bitCnt_reg == i2c_target_pkg::BYTE_BITS);

    always_comb begin
        state_next = state_reg;
        evTgl_next = evTgl_reg;
        wrHold_next = wrHold_reg;
        bitCnt_next = bitCnt_reg;
        shift_next = shift_reg;
        index_next = index_reg;
        rdHold_next = rdAckHit ? rdDataX_reg : rdHold_reg;
        drive_next = drive_reg;
        dirRead_next = dirRead_reg;
        hostAck_next = hostAck_reg;
        busy_next = busy_reg;
        // [RL18] clock falls restart the timer
        if (sclFall && busy_reg) begin
            evTgl_next.sclFall = ~evTgl_reg.sclFall;
        end
        if (timeoutHit) begin
            // [RL23] time-out idles engine
            state_next = i2c_target_pkg::LINK_IDLE;
            drive_next = 1'b0;
            busy_next = 1'b0;
        end else if (startEv) begin
            // [RL8] repeated start as start
            state_next = i2c_target_pkg::LINK_ADDR;
            bitCnt_next = '0;
            drive_next = 1'b0;
            busy_next = 1'b1;
            evTgl_next.start = ~evTgl_reg.start;
        end else if (stopEv) begin
            // [RL23] stop idles engine
            state_next = i2c_target_pkg::LINK_IDLE;
            drive_next = 1'b0;
            busy_next = 1'b0;
            evTgl_next.stop = ~evTgl_reg.stop;
        end else begin
            case (state_reg)
                i2c_target_pkg::LINK_ADDR,
                i2c_target_pkg::LINK_INDEX,
                i2c_target_pkg::LINK_WDATA: begin
                    // [RL10] msb first receive
                    if (sclRise) begin
                        shift_next = {shift_reg[6:0], sdaLvl};
                        bitCnt_next = bitCnt_reg + 4'h1;
                    end else if (byteDone) begin
                        // [RL9] eight bits per byte
                        bitCnt_next = '0;
                        drive_next = 1'b1;
                        if (state_reg == i2c_target_pkg::LINK_ADDR) begin
                            // [RL19] address compare
                            if (shift_reg[7:1] == i2c_target_pkg::TARGET_ADDR) begin
                                state_next = i2c_target_pkg::LINK_ADDR_ACK;
                                dirRead_next = shift_reg[0];
                                if (shift_reg[0]) begin
                                    evTgl_next.read = ~evTgl_reg.read;
                                end
                            end else begin
                                // [RL22] stay released
                                state_next = i2c_target_pkg::LINK_IGNORE;
                                drive_next = 1'b0;
                            end
                        end else if (state_reg == i2c_target_pkg::LINK_INDEX) begin
                            // [RL20] index byte
                            index_next = shift_reg;
                            state_next = i2c_target_pkg::LINK_INDEX_ACK;
                        end else begin
                            // [RL20] data byte written
                            wrHold_next = '{index: index_reg, data: shift_reg};
                            evTgl_next.write = ~evTgl_reg.write;
                            index_next = index_reg + i2c_target_pkg::INDEX_STEP;
                            state_next = i2c_target_pkg::LINK_WDATA_ACK;
                        end
                    end
                end
                i2c_target_pkg::LINK_ADDR_ACK: begin
                    // [RL13] ack held to clock fall
                    if (sclFall) begin
                        if (dirRead_reg) begin
                            // [RL21] first read byte
                            state_next = i2c_target_pkg::LINK_RDATA;
                            shift_next = rdHold_reg;
                            drive_next = ~rdHold_reg[7];
                        end else begin
                            state_next = i2c_target_pkg::LINK_INDEX;
                            drive_next = 1'b0;
                        end
                    end
                end
                i2c_target_pkg::LINK_INDEX_ACK,
                i2c_target_pkg::LINK_WDATA_ACK: begin
                    // [RL12] ack every byte
                    if (sclFall) begin
                        state_next = i2c_target_pkg::LINK_WDATA;
                        drive_next = 1'b0;
                    end
                end
                i2c_target_pkg::LINK_RDATA: begin
                    if (sclRise) begin
                        bitCnt_next = bitCnt_reg + 4'h1;
                    end else if (byteDone) begin
                        // [RL11] release for host ack
                        bitCnt_next = '0;
                        drive_next = 1'b0;
                        hostAck_next = 1'b0;
                        state_next = i2c_target_pkg::LINK_RDATA_ACK;
                    end else if (sclFall) begin
                        // [RL4] change only while clock low
                        shift_next = {shift_reg[6:0], 1'b0};
                        drive_next = ~shift_reg[6];
                    end
                end
                i2c_target_pkg::LINK_RDATA_ACK: begin
                    if (sclRise) begin
                        hostAck_next = ~sdaLvl;
                        if (!sdaLvl) begin
                            index_next = index_reg + i2c_target_pkg::INDEX_STEP;
                            evTgl_next.read = ~evTgl_reg.read;
                        end
                    end else if (sclFall) begin
                        if (hostAck_reg) begin
                            state_next = i2c_target_pkg::LINK_RDATA;
                            shift_next = rdHold_reg;
                            drive_next = ~rdHold_reg[7];
                        end else begin
                            // [RL14] host nack ends reading
                            state_next = i2c_target_pkg::LINK_IGNORE;
                        end
                    end
                end
                default: begin
                    drive_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge linkClk) begin
        if (linkReset) begin
            state_reg <= i2c_target_pkg::LINK_IDLE;
            evTgl_reg <= '0;
            wrHold_reg <= '0;
            bitCnt_reg <= '0;
            shift_reg <= '0;
            index_reg <= i2c_target_pkg::INDEX_RESET;
            rdHold_reg <= '0;
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
            drive_reg <= 1'b0;
            dirRead_reg <= 1'b0;
            hostAck_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            evTgl_reg <= evTgl_next;
            wrHold_reg <= wrHold_next;
            bitCnt_reg <= bitCnt_next;
            shift_reg <= shift_next;
            index_reg <= index_next;
            rdHold_reg <= rdHold_next;
            sclPrev_reg <= sclLvl;
            sdaPrev_reg <= sdaLvl;
            drive_reg <= drive_next;
            dirRead_reg <= dirRead_next;
            hostAck_reg <= hostAck_next;
            busy_reg <= busy_next;
        end
    end

    // [RL1] pull low only, clock never driven
    assign sdaOut = 1'b0;
    assign sdaOe = drive_reg;
    // [RL7] no start or stop generated
    assign sclOut = 1'b0;
    assign sclOe = 1'b0;

    // ==========================================================
    // Link events into system domain
    i2c_target_pkg::link_events_t ev1_reg, ev2_reg, ev3_reg, evEdge;
    logic [1:0] busySync_reg, busySync_next;

    assign evEdge = ev2_reg ^ ev3_reg;
    // [RL2] idle shown as not busy
    assign busySync_next = {busySync_reg[0], busy_reg};

    always_ff @(posedge clk) begin
        if (reset) begin
            ev1_reg <= '0;
            ev2_reg <= '0;
            ev3_reg <= '0;
            busySync_reg <= 2'h0;
        end else begin
            ev1_reg <= evTgl_reg;
            ev2_reg <= ev1_reg;
            ev3_reg <= ev2_reg;
            busySync_reg <= busySync_next;
        end
    end

    // ==========================================================
    // Time-out
    logic trim_reg, trim_next;
    logic expired;

    assign trim_next = reset ? trimLong : trim_reg;

    always_ff @(posedge clk) begin
        trim_reg <= trim_next;
    end

    bus_timeout_timer #(
        .WIDTH(i2c_target_pkg::TOUT_WIDTH),
        .SHORT_CYCLES(TOUT_SHORT_CYCLES),
        .LONG_CYCLES(TOUT_LONG_CYCLES)
    ) timeoutTimer (
        .clk(clk),
        .reset(reset),
        .longSel(trim_reg),
        .restart(evEdge.start | evEdge.sclFall),
        .halt(evEdge.stop),
        .expired(expired)
    );

    // ==========================================================
    // Register access side
    i2c_target_pkg::reg_write_t regWrite_reg, regWrite_next;
    logic regWriteValid_reg, regWriteValid_next;
    logic [7:0] regReadIndex_reg, regReadIndex_next;
    logic [7:0] rdData_next;
    logic rdPending_reg, rdPending_next;
    logic rdAckTgl_next, timeoutTgl_next;

    always_comb begin
        regWrite_next = regWrite_reg;
        regWriteValid_next = evEdge.write;
        regReadIndex_next = regReadIndex_reg;
        rdData_next = rdDataX_reg;
        rdPending_next = 1'b0;
        rdAckTgl_next = rdAckTgl_reg;
        // [RL18] expiry releases the bus, registers kept
        timeoutTgl_next = timeoutTgl_reg ^ expired;
        if (evEdge.write) begin
            regWrite_next = wrHold_reg;
        end
        if (evEdge.read) begin
            regReadIndex_next = index_reg;
            rdPending_next = 1'b1;
        end
        if (rdPending_reg) begin
            rdData_next = regReadData;
            rdAckTgl_next = ~rdAckTgl_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            regWrite_reg <= '0;
            regWriteValid_reg <= 1'b0;
            regReadIndex_reg <= i2c_target_pkg::INDEX_RESET;
            rdDataX_reg <= '0;
            rdPending_reg <= 1'b0;
            rdAckTgl_reg <= 1'b0;
            timeoutTgl_reg <= 1'b0;
        end else begin
            regWrite_reg <= regWrite_next;
            regWriteValid_reg <= regWriteValid_next;
            regReadIndex_reg <= regReadIndex_next;
            rdDataX_reg <= rdData_next;
            rdPending_reg <= rdPending_next;
            rdAckTgl_reg <= rdAckTgl_next;
            timeoutTgl_reg <= timeoutTgl_next;
        end
    end

    assign regWrite = regWrite_reg;
    assign regWriteValid = regWriteValid_reg;
    assign regReadIndex = regReadIndex_reg;
    assign busBusy = busySync_reg[1];

endmodule // battery_monitor_i2c_target

// >>> verification/i2c_host_model.sv
// Behavioural two-wire bus controller
module i2c_host_model (
    // Wire levels
    input wire logic sda,
    // Pull-downs
    output logic sclLow,
    output logic sdaLow
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
    end
    task automatic bitIo(input logic b, output logic r);
        #650 sdaLow = !b;
        #650 sclLow = 1'b0;
        #700 r = sda;
        sclLow = 1'b1;
    endtask
    task automatic start();
        #650 sdaLow = 1'b0;
        #650 sclLow = 1'b0;
        #700 sdaLow = 1'b1;
        #700 sclLow = 1'b1;
    endtask
    task automatic stop();
        #650 sdaLow = 1'b1;
        #650 sclLow = 1'b0;
        #700 sdaLow = 1'b0;
        #1300;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) bitIo(d[i], q[i]);
        bitIo(ackIn, ack);
    endtask
endmodule // i2c_host_model

// >>> verification/i2c_target_monitor.sv
// Port checker for the two-wire target
module i2c_target_monitor #(
    parameter int TOUT_LONG_CYCLES = 2000
) (
    // Clocks and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic linkClk,
    // Bus pins
    input wire logic sclIn,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // Register side
    input wire logic regWriteValid,
    input wire logic [7:0] regReadIndex,
    input wire logic busBusy
);
    int idleCnt;
    logic sclSeen;
    always_ff @(posedge clk) begin
        sclSeen <= sclIn;
        idleCnt <= (reset || sclIn != sclSeen || !busBusy) ? 0 : idleCnt + 1;
    end
    property p_scl_free;
        @(posedge clk) disable iff (reset) !sclOe && !sclOut;
    endproperty
    a_scl_free: assert property (p_scl_free) else $error("scl driven");
    property p_sda_low;
        @(posedge linkClk) disable iff (reset) sdaOe |-> !sdaOut;
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("sda high");
    property p_sda_hold;
        @(posedge linkClk) disable iff (reset) sclIn [*8] |-> $stable(sdaOe);
    endproperty
    a_sda_hold: assert property (p_sda_hold) else $error("sda moved");
    property p_wr_pulse;
        @(posedge clk) disable iff (reset) regWriteValid |=> !regWriteValid;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("long write");
    property p_wr_busy;
        @(posedge clk) disable iff (reset) regWriteValid |-> busBusy;
    endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("write idle");
    property p_idle_quiet;
        @(posedge clk) disable iff (reset) !busBusy [*8] |-> !sdaOe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("sda idle");
    property p_rd_busy;
        @(posedge clk) disable iff (reset) $changed(regReadIndex) |-> busBusy;
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("read idle");
    property p_timeout;
        @(posedge clk) disable iff (reset) idleCnt > TOUT_LONG_CYCLES + 64 |-> !busBusy;
    endproperty
    a_timeout: assert property (p_timeout) else $error("no time-out");
    c_write: cover property (@(posedge clk) regWriteValid);
    c_ack: cover property (@(posedge linkClk) $rose(sdaOe));
    c_free: cover property (@(posedge clk) $fell(busBusy));
endmodule // i2c_target_monitor
bind battery_monitor_i2c_target i2c_target_monitor #(.TOUT_LONG_CYCLES(TOUT_LONG_CYCLES))
    i2c_target_monitor_inst (.clk(clk), .reset(reset), .linkClk(linkClk), .sclIn(sclIn),
    .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .regWriteValid(regWriteValid), .regReadIndex(regReadIndex), .busBusy(busBusy));

// >>> verification/tb.sv
// Testbench for the two-wire target
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, linkClk = 1'b0, reset = 1'b1, trim = 1'b0;
    logic sclOut, sclOe, sdaOut, sdaOe, regWriteValid, busBusy, sclLow, sdaLow, ack;
    wire logic scl = !(sclLow || sclOe);
    wire logic sda = !(sdaLow || sdaOe);
    i2c_target_pkg::reg_write_t regWrite, lastWr;
    logic [7:0] regReadIndex, got;
    int failures = 0, check_count = 0, wrCnt = 0;
    always #4 clk = !clk;
    initial begin
        #2.3;
        forever #6 linkClk = !linkClk;
    end
    always @(posedge clk) if (regWriteValid === 1'b1) begin
        lastWr <= regWrite;
        wrCnt <= wrCnt + 1;
    end
    battery_monitor_i2c_target #(.TOUT_SHORT_CYCLES(1000), .TOUT_LONG_CYCLES(2000))
        battery_monitor_i2c_target_inst (.clk(clk), .reset(reset), .linkClk(linkClk),
        .trimLong(trim), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .regWrite(regWrite), .regWriteValid(regWriteValid),
        .regReadIndex(regReadIndex), .regReadData(regReadIndex ^ 8'h3c), .busBusy(busBusy));
    i2c_host_model i2c_host_model_inst (.sda(sda), .sclLow(sclLow), .sdaLow(sdaLow));
    task automatic check8(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic check1(input logic g, input logic e);
        check8({7'h00, g}, {7'h00, e});
    endtask
    task automatic end_of_test();
        $display("%0d checks %0d fails", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic addr(input logic [7:0] a, input logic e);
        i2c_host_model_inst.start();
        i2c_host_model_inst.xfer(a, 1'b1, got, ack);
        check1(ack, e);
    endtask
    task automatic test_write();
        addr(8'hb8, 1'b0);
        i2c_host_model_inst.xfer(8'h01, 1'b1, got, ack);
        check1(ack, 1'b0);
        i2c_host_model_inst.xfer(8'ha5, 1'b1, got, ack);
        check1(ack, 1'b0);
        check8(lastWr.index, 8'h01);
        check8(lastWr.data, 8'ha5);
        i2c_host_model_inst.stop();
        check1(busBusy, 1'b0);
        $display("write done");
    endtask
    task automatic test_read();
        addr(8'hb8, 1'b0);
        i2c_host_model_inst.xfer(8'h01, 1'b1, got, ack);
        addr(8'hb9, 1'b0);
        i2c_host_model_inst.xfer(8'hff, 1'b1, got, ack);
        check8(got, 8'h01 ^ 8'h3c);
        i2c_host_model_inst.stop();
        $display("read done");
    endtask
    task automatic test_nomatch();
        addr(8'hba, 1'b1);
        i2c_host_model_inst.xfer(8'h00, 1'b1, got, ack);
        check1(ack, 1'b1);
        i2c_host_model_inst.stop();
        check1(wrCnt == 1, 1'b1);
        $display("no-match done");
    endtask
    task automatic test_timeout(input logic t);
        addr(8'hb8, 1'b0);
        check1(busBusy, 1'b1);
        repeat (1100) @(posedge clk);
        check1(busBusy, t);
        i2c_host_model_inst.stop();
        trim = 1'b1;
        reset = 1'b1;
        repeat (6) @(posedge clk);
        #1 reset = 1'b0;
        $display("time-out done");
    endtask
    initial begin
        #700000;
        failures++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 reset = 1'b0;
        repeat (20) @(posedge clk);
        test_write();
        test_read();
        test_nomatch();
        test_timeout(1'b0);
        test_timeout(1'b1);
        end_of_test();
    end
endmodule // tb
